// ---- rtl/afd_pkg.sv ----
// Constants, field layout and carrier types for the auto fan duty ramp block
package afd_pkg;

   // Clock and ramp timebase
   localparam int CLK_HZ       = 40_000_000;
   localparam int TICK_MS      = 1;
   localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

   // APB address width; each register index sits at byte address index*4
   localparam int ADDR_W       = 12;

   // Register indices
   localparam logic [7:0] IDX_RAMP1   = 8'h62;
   localparam logic [7:0] IDX_RAMP23  = 8'h63;
   localparam logic [7:0] IDX_MIN1    = 8'h64;
   localparam logic [7:0] IDX_MIN2    = 8'h65;
   localparam logic [7:0] IDX_MIN3    = 8'h66;
   localparam logic [7:0] IDX_LOW1    = 8'h67;
   localparam logic [7:0] IDX_LOW2    = 8'h68;
   localparam logic [7:0] IDX_LOW3    = 8'h69;
   localparam logic [7:0] IDX_LOCK    = 8'h80;
   localparam logic [7:0] IDX_RANGE12 = 8'h81;
   localparam logic [7:0] IDX_RANGE3  = 8'h82;
   localparam logic [7:0] IDX_DUTY1   = 8'h83;
   localparam logic [7:0] IDX_DUTY2   = 8'h84;
   localparam logic [7:0] IDX_DUTY3   = 8'h85;

   // Field positions
   localparam int RAMP1_EN_BIT  = 3;
   localparam int RAMP1_SEL_LSB = 0;
   localparam int RAMP2_EN_BIT  = 7;
   localparam int RAMP2_SEL_LSB = 4;
   localparam int RAMP3_EN_BIT  = 3;
   localparam int RAMP3_SEL_LSB = 0;
   localparam int RANGE_A_LSB   = 0;
   localparam int RANGE_B_LSB   = 4;
   localparam int LOCK_BIT      = 0;
   localparam logic [7:0] RESERVED_READ_ONE_MASK = 8'hE0;

   // Reset values
   localparam logic [3:0] RAMP1_RST  = 4'h0;
   localparam logic [7:0] RAMP23_RST = 8'h00;
   localparam logic [7:0] MIN_RST    = 8'h80;
   localparam logic [7:0] LOW_RST    = 8'h80;
   localparam logic [3:0] RANGE_RST  = 4'hC;

   localparam logic [7:0] DUTY_FULL  = 8'hFF;
   localparam logic [7:0] DUTY_OFF   = 8'h00;

   // Milliseconds per one-step change of duty, by interval code
   localparam logic [7:0] STEP_MS [8] = '{8'd206, 8'd104, 8'd69, 8'd41,
                                          8'd26, 8'd18, 8'd10, 8'd5};

   // Temperature range in whole degrees, fractions rounded up
   localparam logic [6:0] RANGE_DEG [16] = '{7'd2, 7'd3, 7'd4, 7'd4,
                                             7'd5, 7'd7, 7'd8, 7'd10,
                                             7'd14, 7'd16, 7'd20, 7'd27,
                                             7'd32, 7'd40, 7'd54, 7'd80};

   // One temperature reading with its strobe
   typedef struct packed {
      logic [7:0] temp;
      logic       valid;
   } afd_temp_in_t;

endpackage

// ---- rtl/afd_ramp_limits.sv ----
// Auto fan duty: minimum duty, low limits, target calculation, ramp limiter
// What this block does
// [R01] Lock bit makes ramp, minimum duty and low-limit registers ignore writes.
// [R02] Top three bits of the first ramp register read one, writes ignored.
// [R03] A new target duty is computed for every temperature reading.
// [R04] Ramp disabled: output duty jumps straight to each new target.
// [R05] Ramp enabled: output duty moves gradually toward target, never jumps.
// [R06] Ramp moves duty one 1/255 step per programmed interval.
// [R07] Ramp enables: ch1 bit 3 of first, ch2 bit 7, ch3 bit 3 of second.
// [R08] Channel one interval code is bits 2..0 of the first ramp register.
// [R09] Ch2 interval bits 6..4, ch3 bits 2..0 of the second ramp register.
// [R10] Interval codes 0..7 mean 206,104,69,41,26,18,10,5 ms per step.
// [R11] At the zone low limit the channel outputs its minimum duty.
// [R12] Minimum duty is a fraction of 255, 00h off to FFh full.
// [R13] Temperature equal to the low limit switches the fan on.
// [R14] Above the low limit duty rises per the zone range setting.
// [R15] Low limits are signed two's-complement degrees Celsius.
// [R16] Low limits return to default when main supply good asserts.
// [R17] Zones use remote diode one, ambient, remote diode two readings.
// [R18] Between limit and limit plus range duty rises linearly to full.
// [R19] Above limit plus range the target duty is full scale.
// [R20] Ramp holds duty at target and resumes stepping if target moves.
// [R21] Low-limit reset value is 80h.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

module afd_ramp_limits #(
   parameter int TICK_CYCLES = afd_pkg::TICK_CYCLES // Clocks per ms tick
) (
   input  wire logic                         clk,            // 40 MHz clock
   input  wire logic                         nrst,           // Sync reset
   input  wire logic                         psel,           // APB select
   input  wire logic                         penable,        // APB enable
   input  wire logic                         pwrite,         // APB write
   input  wire logic [afd_pkg::ADDR_W-1:0]   paddr,          // APB address
   input  wire logic [31:0]                  pwdata,         // APB wdata
   output logic      [31:0]                  prdata,         // APB rdata
   output logic                              pready,         // APB ready
   output logic                              pslverr,        // APB error
   input  wire afd_pkg::afd_temp_in_t [2:0]  tempIn,         // Zone readings
   input  wire logic                         mainSupplyGood, // Supply good
   output logic      [2:0][7:0]              duty            // PWM duties
);
   import afd_pkg::*;

   logic [3:0]      ramp1Reg;
   logic [7:0]      ramp23Reg;
   logic [2:0][7:0] minReg;
   logic [2:0][7:0] lowReg;
   logic [2:0][3:0] rangeReg;
   logic            lockReg;
   logic            supplyPrevReg;
   logic [2:0][7:0] targetReg;
   logic [2:0][7:0] dutyReg;
   logic [2:0][7:0] stepCntReg;
   logic [15:0]     msCntReg;
   logic            msTickReg;
   logic            preadyReg;
   logic            pslverrReg;
   logic [31:0]     prdataReg;

   // Bus decode
   // Index bits above the byte index must be zero, or the map would alias
   wire [7:0] idx      = paddr[9:2];
   wire       aligned  = paddr[1:0] == 2'b00
                         && paddr[ADDR_W-1:10] == '0;
   wire       setup    = psel && !penable && !preadyReg;
   wire       wrEn     = psel && penable && preadyReg && pwrite;
   wire       wrOpen   = wrEn && !lockReg;                         // R01
   wire [7:0] wbyte    = pwdata[7:0];
   wire       hitRamp1 = aligned && idx == IDX_RAMP1;
   wire       hitRamp2 = aligned && idx == IDX_RAMP23;
   wire       hitMin1  = aligned && idx == IDX_MIN1;
   wire       hitMin2  = aligned && idx == IDX_MIN2;
   wire       hitMin3  = aligned && idx == IDX_MIN3;
   wire       hitLow1  = aligned && idx == IDX_LOW1;
   wire       hitLow2  = aligned && idx == IDX_LOW2;
   wire       hitLow3  = aligned && idx == IDX_LOW3;
   wire       hitLock  = aligned && idx == IDX_LOCK;
   wire       hitRngA  = aligned && idx == IDX_RANGE12;
   wire       hitRngB  = aligned && idx == IDX_RANGE3;
   wire       hitDuty1 = aligned && idx == IDX_DUTY1;
   wire       hitDuty2 = aligned && idx == IDX_DUTY2;
   wire       hitDuty3 = aligned && idx == IDX_DUTY3;
   wire [2:0] hitMin   = {hitMin3, hitMin2, hitMin1};
   wire [2:0] hitLow   = {hitLow3, hitLow2, hitLow1};
   wire       mapped   = hitRamp1 || hitRamp2 || (|hitMin) || (|hitLow)
                         || hitLock || hitRngA || hitRngB
                         || hitDuty1 || hitDuty2 || hitDuty3;
   wire       supplyRise = mainSupplyGood && !supplyPrevReg;         // R16

   // Read selection; unmapped reads return zero with an error
   wire [7:0] rdByte =
      hitRamp1 ? (RESERVED_READ_ONE_MASK | {4'h0, ramp1Reg}) :                   // R02
      hitRamp2 ? ramp23Reg :
      hitMin1  ? minReg[0] :
      hitMin2  ? minReg[1] :
      hitMin3  ? minReg[2] :
      hitLow1  ? lowReg[0] :
      hitLow2  ? lowReg[1] :
      hitLow3  ? lowReg[2] :
      hitLock  ? {7'h00, lockReg} :
      hitRngA  ? {rangeReg[1], rangeReg[0]} :
      hitRngB  ? {4'h0, rangeReg[2]} :
      hitDuty1 ? dutyReg[0] :
      hitDuty2 ? dutyReg[1] :
      hitDuty3 ? dutyReg[2] : 8'h00;

   // Channel field extraction
   wire [2:0]      rampEn;
   wire [2:0][2:0] rampSel;
   assign rampEn[0]  = ramp1Reg[RAMP1_EN_BIT];                       // R07
   assign rampEn[1]  = ramp23Reg[RAMP2_EN_BIT];                      // R07
   assign rampEn[2]  = ramp23Reg[RAMP3_EN_BIT];                      // R07
   assign rampSel[0] = ramp1Reg[RAMP1_SEL_LSB +: 3];                 // R08
   assign rampSel[1] = ramp23Reg[RAMP2_SEL_LSB +: 3];                // R09
   assign rampSel[2] = ramp23Reg[RAMP3_SEL_LSB +: 3];                // R09

   // Zero-wait slave: ready rises in the first access cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         preadyReg  <= 1'b0;
         pslverrReg <= 1'b0;
         prdataReg  <= 32'h0000_0000;
      end else begin
         preadyReg  <= setup;
         pslverrReg <= setup && !mapped;
         prdataReg  <= setup && !pwrite ? {24'h00_0000, rdByte} : prdataReg;
      end
   end

   // Ramp and range settings; reserved bit 4 of ramp1 is not stored
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ramp1Reg  <= RAMP1_RST;
         ramp23Reg <= RAMP23_RST;
         rangeReg  <= {3{RANGE_RST}};
         lockReg   <= 1'b0;
      end else begin
         if (wrOpen && hitRamp1)
            ramp1Reg <= wbyte[3:0];                                  // R02
         if (wrOpen && hitRamp2)
            ramp23Reg <= wbyte;
         if (wrOpen && hitRngA)
            rangeReg[1:0] <= {wbyte[RANGE_B_LSB +: 4], wbyte[RANGE_A_LSB +: 4]};
         if (wrOpen && hitRngB)
            rangeReg[2] <= wbyte[RANGE_A_LSB +: 4];
         // Lock is set-once; only reset releases it
         if (wrEn && hitLock && wbyte[LOCK_BIT])
            lockReg <= 1'b1;
      end
   end

   // Common millisecond tick
   always_ff @(posedge clk) begin
      if (!nrst) begin
         msCntReg      <= 16'h0000;
         msTickReg     <= 1'b0;
         supplyPrevReg <= 1'b0;
      end else begin
         msTickReg     <= msCntReg == 16'(TICK_CYCLES - 1);
         msCntReg      <= msCntReg == 16'(TICK_CYCLES - 1) ? 16'h0000
                                                           : msCntReg + 16'h0001;
         supplyPrevReg <= mainSupplyGood;
      end
   end

   // Per channel: tempIn[0] remote diode 1, [1] ambient, [2] remote diode 2
   wire [2:0][7:0] calcDuty;
   wire [2:0]      stepDue;
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_ch                         // R17
         wire signed [8:0] diff =
            $signed({tempIn[ch].temp[7], tempIn[ch].temp})
            - $signed({lowReg[ch][7], lowReg[ch]});                  // R15
         wire [7:0]  span    = DUTY_FULL - minReg[ch];               // R12
         wire [6:0]  rng     = RANGE_DEG[rangeReg[ch]];              // R14
         wire [15:0] prod    = span * diff[7:0];
         wire [15:0] quot    = prod / {9'h000, rng};                 // R18
         wire [7:0]  linear  = minReg[ch] + quot[7:0];               // R18
         wire        below   = diff < 0;
         wire        atLimit = diff == 0;                            // R13
         wire        over    = diff >= $signed({2'b00, rng});        // R19
         wire [7:0]  stepLen = STEP_MS[rampSel[ch]];                 // R10

         assign calcDuty[ch] = below   ? DUTY_OFF :
                               atLimit ? minReg[ch] :                // R11
                               over    ? DUTY_FULL : linear;         // R19
         assign stepDue[ch]  = msTickReg
                               && stepCntReg[ch] >= stepLen - 8'd1;  // R06

         wire up   = dutyReg[ch] < targetReg[ch];                    // R20
         wire down = dutyReg[ch] > targetReg[ch];                    // R20
         wire [7:0] dutyNext =
            !rampEn[ch]          ? targetReg[ch] :                   // R04
            stepDue[ch] && up    ? dutyReg[ch] + 8'd1 :              // R05
            stepDue[ch] && down  ? dutyReg[ch] - 8'd1 :              // R05
                                   dutyReg[ch];                      // R20

         always_ff @(posedge clk) begin
            if (!nrst) begin
               minReg[ch]     <= MIN_RST;
               lowReg[ch]     <= LOW_RST;                            // R21
               targetReg[ch]  <= DUTY_OFF;
               dutyReg[ch]    <= DUTY_OFF;
               stepCntReg[ch] <= 8'h00;
            end else begin
               if (wrOpen && hitMin[ch])
                  minReg[ch] <= wbyte;                               // R01
               if (supplyRise)
                  lowReg[ch] <= LOW_RST;                             // R16
               else if (wrOpen && hitLow[ch])
                  lowReg[ch] <= wbyte;                               // R01
               if (tempIn[ch].valid)
                  targetReg[ch] <= calcDuty[ch];                     // R03
               dutyReg[ch] <= dutyNext;
               if (stepDue[ch])
                  stepCntReg[ch] <= 8'h00;
               else if (msTickReg)
                  stepCntReg[ch] <= stepCntReg[ch] + 8'd1;
            end
         end
      end
   endgenerate

   assign prdata  = prdataReg;
   assign pready  = preadyReg;
   assign pslverr = pslverrReg;
   assign duty    = dutyReg;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence rampOnSeq;
      rampEn[0] ##1 rampEn[0];
   endsequence

   sequence rampOffSeq;
      !rampEn[0] ##1 !rampEn[0];
   endsequence

   lock_hold_a: assert property ( // R01
      lockReg && wrEn && !supplyRise |=> $stable(minReg) && $stable(lowReg)
         && $stable(ramp1Reg) && $stable(ramp23Reg))
      else $error("locked register changed on write");

   reserved_read_one_read_a: assert property ( // R02
      setup && !pwrite && hitRamp1 |=> prdata[7:5] == 3'b111
         && prdata[4] == 1'b0 && pready)
      else $error("reserved ramp bits read wrong");

   target_take_a: assert property ( // R03
      tempIn[0].valid |=>
         targetReg[0] == $past(calcDuty[0]))
      else $error("reading did not update target");

   direct_follow_a: assert property ( // R04
      rampOffSeq |-> duty[0] == $past(targetReg[0]))
      else $error("unramped duty did not follow target");

   ramp_small_a: assert property ( // R05
      rampOnSeq |-> (duty[0] == $past(duty[0])
         || duty[0] == $past(duty[0]) + 8'd1
         || duty[0] == $past(duty[0]) - 8'd1))
      else $error("ramped duty jumped");

   step_on_tick_a: assert property ( // R06
      rampOnSeq ##0 (duty[0] != $past(duty[0])) |->
         $past(stepDue[0]))
      else $error("ramp stepped without interval elapsing");

   ramp_hold_a: assert property ( // R20
      rampEn[0] && dutyReg[0] == targetReg[0] && !tempIn[0].valid
         ##1 rampEn[0] |-> dutyReg[0] == $past(dutyReg[0]))
      else $error("ramp left target");

   min_at_limit_a: assert property ( // R11
      tempIn[1].temp == lowReg[1] |-> calcDuty[1] == minReg[1])
      else $error("duty at low limit is not minimum");

   full_above_a: assert property ( // R19
      $signed({tempIn[2].temp[7], tempIn[2].temp})
         > $signed({lowReg[2][7], lowReg[2]})
         + $signed({2'b00, RANGE_DEG[rangeReg[2]]})
         |-> calcDuty[2] == DUTY_FULL)
      else $error("duty not full above range");

   supply_reload_a: assert property ( // R16
      supplyRise |=> lowReg[0] == LOW_RST && lowReg[1] == LOW_RST
         && lowReg[2] == LOW_RST)
      else $error("low limits not reloaded on supply good");

endmodule

// ---- sim/afd_fan_model.sv ----
// Fan partner model driven by one PWM duty output
`timescale 1ns/1ps

module afd_fan_model (
   input  wire logic [7:0] duty,     // PWM duty from the block
   output logic            spinning  // Rotor turning
);
   // Zero duty stops the rotor; any other duty keeps it turning
   assign spinning = (duty !== 8'h00);
endmodule

// ---- sim/tb_auto_fan_duty_ramp_limits.sv ----
// Self-checking bench for the auto fan duty ramp block
`timescale 1ns/1ps

module tb_auto_fan_duty_ramp_limits;
   import afd_pkg::*;
   // Short tick keeps the slowest step interval under a thousand clocks
   localparam int TK = 4;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [ADDR_W-1:0]   paddr = '0;
   logic [31:0]         pwdata = '0;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   afd_temp_in_t [2:0]  tempIn = '0;
   logic                mainSupplyGood = 1'b1;
   logic [2:0][7:0]     duty;
   logic [2:0]          spin;
   int                  err_total = 0;
   int                  comparisons = 0;
   logic [7:0]          lows [3] = '{8'hCE, 8'h00, 8'h32};

   always #12.5 clk = ~clk;

   afd_ramp_limits #(.TICK_CYCLES(TK)) DUT (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tempIn(tempIn), .mainSupplyGood(mainSupplyGood), .duty(duty));

   for (genvar g = 0; g < 3; g++) begin : g_fan
      afd_fan_model FAN (.duty(duty[g]), .spinning(spin[g]));
   end

   task automatic report_and_stop;
      if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, idx, 8'h00, r, e);
      check(r, {24'h000000, x});
   endtask

   // Reading strobed at one edge lands on duty two edges later
   task automatic send(input int ch, input logic [7:0] t);
      @(posedge clk);
      tempIn[ch] <= '{temp: t, valid: 1'b1};
      @(posedge clk);
      tempIn[ch].valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic wait_change(input int ch, output int n);
      logic [7:0] p;
      p = duty[ch];
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (duty[ch] === p && n < 1000);
      if (n >= 1000) begin
         err_total++;
         report_and_stop();
      end
   endtask

   function automatic logic [7:0] tgt(input int d);
      if (d < 0) return 8'h00;
      if (d == 0) return 8'h40;
      if (d >= 32) return 8'hFF;
      return 8'(8'h40 + (191 * d) / 32);
   endfunction

   task automatic t_reset;
      logic [7:0]  x [8] = '{8'hE0, 8'h00, 8'h80, 8'h80,
                             8'h80, 8'h80, 8'h80, 8'h80};
      logic [31:0] r;
      logic        e;
      for (int i = 0; i < 8; i++) rd_chk(IDX_RAMP1 + 8'(i), x[i]);
      apb(1'b0, 8'h70, 8'h00, r, e);
      check(e, 1'b1);
      check(r, 32'h0);
   endtask

   task automatic t_reserved;
      wr(IDX_RAMP1, 8'h1F);
      rd_chk(IDX_RAMP1, 8'hEF);
      wr(IDX_RAMP1, 8'h00);
      rd_chk(IDX_RAMP1, 8'hE0);
   endtask

   task automatic t_target;
      int ds [5] = '{-1, 0, 16, 32, 50};
      for (int ch = 0; ch < 3; ch++) begin
         wr(IDX_MIN1 + 8'(ch), 8'h40);
         wr(IDX_LOW1 + 8'(ch), lows[ch]);
         foreach (ds[k]) begin
            send(ch, lows[ch] + 8'(ds[k]));
            check(duty[ch], tgt(ds[k]));
            if (ds[k] == 0) check(spin[ch], 1'b1);
         end
      end
   endtask

   task automatic t_ramp(input int code);
      int         ch;
      int         n;
      logic [2:0] c;
      logic [7:0] v;
      logic [7:0] p;
      ch = code % 3;
      c = code[2:0];
      wr(IDX_RAMP1, 8'h00);
      wr(IDX_RAMP23, 8'h00);
      send(ch, 8'h7F);
      check(duty[ch], 8'hFF);
      v = (ch == 1) ? {1'b1, c, 4'h0} : {4'h0, 1'b1, c};
      wr((ch == 0) ? IDX_RAMP1 : IDX_RAMP23, v);
      send(ch, 8'h80);
      check(duty[ch] >= 8'hFE, 1'b1);
      wait_change(ch, n);
      p = duty[ch];
      wait_change(ch, n);
      check(n, STEP_MS[code] * TK);
      check(duty[ch], p - 8'h01);
      send(ch, 8'h7F);
      wait_change(ch, n);
      check(duty[ch], p);
   endtask

   task automatic t_supply;
      wr(IDX_LOW2, 8'h11);
      @(posedge clk);
      mainSupplyGood <= 1'b0;
      repeat (2) @(posedge clk);
      mainSupplyGood <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(IDX_LOW2, 8'h80);
   endtask

   task automatic t_lock;
      logic [31:0] r;
      logic        e;
      wr(IDX_LOCK, 8'h01);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, IDX_RAMP1 + 8'(i), 8'h00, r, e);
         wr(IDX_RAMP1 + 8'(i), 8'h5A);
         rd_chk(IDX_RAMP1 + 8'(i), r[7:0]);
      end
   endtask

   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_reserved();
      t_target();
      for (int code = 0; code < 8; code++) t_ramp(code);
      t_supply();
      t_lock();
      report_and_stop();
   end
endmodule
